// file: scm_cfg.svh
// Constants for the configuration, map and EPROM programming block.
// Assumes a 32-bit APB master and a 200 MHz clock that is the E clock.
//
// Behaviour
// - Map field gives register block page digit
// - Register block page aligned, at 0x1000 after reset
// - RAM map field gives RAM page, reset 0x0000
// - Protected option bits writable once after reset in normal modes
// - Normal modes: only first 64 cycles; special anytime
// - Delay bit clear: resume within four cycles
// - Delay bit set: wait about 4000 cycles
// - Pump clock select drives pump and converter
// - Option bit 2 always reads zero
// - Watchdog clock divided by 2^15, then scaled
// - Erased cells read ones; programming clears bits
// - Clearing control drops voltage, restores reads
// - Utility at 0xBF00 loads default index values
// - Delay from X index, start pointer 0xD000
// - Utility sends 0xFF, host then sends bytes
// - Verify byte returned per programmed byte
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

`define SCM_IDX_OPTIONS 8'h39
`define SCM_IDX_PROG 8'h3B
`define SCM_IDX_MAP 8'h3D
`define SCM_IDX_UTIL_DLY 8'h30
`define SCM_IDX_UTIL_PTR 8'h31
`define SCM_IDX_UTIL_STATE 8'h32
`define SCM_EPROM_SEL 2'h1

`define SCM_OPT_RESET 8'h10
`define SCM_OPT_PROT_MASK 8'h33
`define SCM_OPT_FREE_MASK 8'hC8
`define SCM_OPT_CONVERTER_POWER_UP_BIT 7
`define SCM_OPT_PUMP_CLOCK_SELECT_BIT 6
`define SCM_OPT_EDGE_ONLY_REQUEST_SELECT_BIT 5
`define SCM_OPT_DLY_BIT 4
`define SCM_OPT_CME_BIT 3
`define SCM_MAP_RESET 8'h01
`define SCM_PROG_LATCH_BIT 5
`define SCM_PROG_VOLT_BIT 0

`define SCM_WINDOW_CYCLES 7'h40
`define SCM_STOP_FAST_CYCLES 13'h0004
`define SCM_STOP_SLOW_CYCLES 13'h0FA0
`define SCM_WD_DIV_LOG2 15
`define SCM_UTIL_ENTRY 16'hBF00
`define SCM_UTIL_PTR_RESET 16'hD000
`define SCM_UTIL_DLY_RESET 16'h0010
`define SCM_READY_CHAR 8'hFF

`endif

// file: scm_pkg.sv
// Types shared by the configuration block.
// Assumes nothing beyond the constants header.
`default_nettype none
package scm_pkg;
    typedef logic [7:0] scm_byte_t;
    typedef enum logic [2:0] {
        U_IDLE = 3'b000,
        U_HELLO = 3'b001,
        U_WAIT = 3'b010,
        U_PROG = 3'b011,
        U_VERIFY = 3'b100
    } scm_util_state_t;
endpackage : scm_pkg
`default_nettype wire

// file: scm_eprom_array.sv
// EPROM cell array with address and data latch.
// Assumes uv_erase is pulsed before first use; cells are not reset.
`default_nettype none
module scm_eprom_array #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic uv_erase,
    input wire logic latch_en,
    input wire logic [AW-1:0] latch_addr,
    input wire scm_pkg::scm_byte_t latch_data,
    input wire logic prog_en,
    input wire logic [AW-1:0] rd_addr,
    output scm_pkg::scm_byte_t rd_data
);
    import scm_pkg::*;
    scm_byte_t mem [DEPTH];
    logic [AW-1:0] addr_q;
    scm_byte_t data_q;

    always_ff @(posedge clk) begin
        if (latch_en) begin
            addr_q <= latch_addr;
            data_q <= latch_data;
        end
    end

    // Programming can only pull bits low; erase restores ones
    always_ff @(posedge clk) begin
        if (uv_erase) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'hFF;
            end
        end else if (prog_en) begin
            mem[addr_q] <= mem[addr_q] & data_q;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule : scm_eprom_array
`default_nettype wire

// file: scm_sysconfig.sv
// Option, map, EPROM programming control and resident utility engine.
// Assumes APB master, synchronous inputs and a byte-stream serial host.
`include "scm_cfg.svh"
`default_nettype none
module scm_sysconfig #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic special_mode,
    input wire logic uv_erase,
    input wire logic stop_exit,
    output logic resume_run,
    output logic [15:0] reg_block_base,
    output logic [15:0] ram_base,
    output logic converter_power_up,
    output logic pump_clock_select,
    output logic edge_only_request_select,
    output logic clock_monitor_enable,
    output logic watchdog_tick,
    output logic array_latch_enable,
    output logic program_voltage_enable,
    input wire logic boot_jump,
    input wire logic rx_valid,
    input wire scm_pkg::scm_byte_t rx_data,
    output logic tx_valid,
    output scm_pkg::scm_byte_t tx_data,
    input wire logic tx_ready,
    output logic util_busy
);
    import scm_pkg::*;

    logic wait_q;
    logic acc;
    logic wr_acc;
    logic [7:0] idx;
    logic is_arr;
    logic [6:0] win_q;
    logic win_open;
    logic [7:0] opt_q;
    logic opt_done_q;
    logic [7:0] map_q;
    logic map_done_q;
    logic latch_q;
    logic volt_q;
    logic [12:0] stop_q;
    logic [20:0] wd_q;
    logic [20:0] wd_mask;
    scm_util_state_t ust_q;
    logic [15:0] dly_q;
    logic [15:0] ptr_q;
    logic [15:0] ucnt_q;
    scm_byte_t hold_q;
    scm_byte_t tx_q;
    scm_byte_t arr_rd;
    logic [AW-1:0] arr_rd_addr;
    logic u_latch;
    logic u_prog;
    logic [31:0] rd_mux;
    logic bad;
    logic [31:0] prdata_q;

    // Access phase lasts two cycles so read data comes from a flop
    assign acc = psel && penable;
    assign pready = acc && wait_q;
    assign wr_acc = pready && pwrite && !pslverr;
    assign idx = paddr[9:2];
    assign is_arr = (paddr[11:10] == `SCM_EPROM_SEL);
    assign prdata = prdata_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= acc && !wait_q;
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        bad = 1'b0;
        if (is_arr) begin
            rd_mux = {24'h0, arr_rd};
            // Latched array cannot be read; writes need the latch
            bad = (int'(paddr[9:2]) >= DEPTH) || !latch_q || util_busy;
            if (!pwrite) begin
                bad = (int'(paddr[9:2]) >= DEPTH) || latch_q;
            end
        end else if (paddr[11:10] != 2'h0) begin
            bad = 1'b1;
        end else begin
            case (idx)
                `SCM_IDX_OPTIONS: rd_mux = {24'h0, opt_q & 8'hFB};
                `SCM_IDX_PROG: rd_mux = {26'h0, latch_q, 4'h0, volt_q};
                `SCM_IDX_MAP: rd_mux = {24'h0, map_q};
                `SCM_IDX_UTIL_DLY: rd_mux = {16'h0, dly_q};
                `SCM_IDX_UTIL_PTR: rd_mux = {16'h0, ptr_q};
                `SCM_IDX_UTIL_STATE: rd_mux = {29'h0, ust_q};
                default: bad = 1'b1;
            endcase
        end
    end

    assign pslverr = pready && bad;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else if (acc && !wait_q && !pwrite) begin
            prdata_q <= bad ? 32'h0 : rd_mux;
        end
    end

    // Write window after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            win_q <= 7'h0;
        end else if (win_q != `SCM_WINDOW_CYCLES) begin
            win_q <= win_q + 7'h1;
        end
    end
    assign win_open = (win_q != `SCM_WINDOW_CYCLES);

    always_ff @(posedge clk) begin
        if (rst) begin
            opt_q <= `SCM_OPT_RESET;
            opt_done_q <= 1'b0;
        end else if (wr_acc && !is_arr && idx == `SCM_IDX_OPTIONS) begin
            opt_q <= (opt_q & ~`SCM_OPT_FREE_MASK & ~8'h04)
                | (pwdata[7:0] & `SCM_OPT_FREE_MASK);
            if (special_mode || (win_open && !opt_done_q)) begin
                opt_q[5:4] <= pwdata[5:4];
                opt_q[1:0] <= pwdata[1:0];
                opt_done_q <= 1'b1;
            end
            // Otherwise protected bits keep their value
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            map_q <= `SCM_MAP_RESET;
            map_done_q <= 1'b0;
        end else if (wr_acc && !is_arr && idx == `SCM_IDX_MAP) begin
            if (special_mode || (win_open && !map_done_q)) begin
                map_q <= pwdata[7:0];
                map_done_q <= 1'b1;
            end
        end
    end

    assign reg_block_base = {map_q[3:0], 12'h000};
    assign ram_base = {map_q[7:4], 12'h000};
    assign converter_power_up = opt_q[`SCM_OPT_CONVERTER_POWER_UP_BIT];
    assign pump_clock_select = opt_q[`SCM_OPT_PUMP_CLOCK_SELECT_BIT];
    assign edge_only_request_select = opt_q[`SCM_OPT_EDGE_ONLY_REQUEST_SELECT_BIT];
    assign clock_monitor_enable = opt_q[`SCM_OPT_CME_BIT];

    // Voltage bit needs a set latch; latch frozen by writes that leave voltage on
    always_ff @(posedge clk) begin
        if (rst) begin
            latch_q <= 1'b0;
            volt_q <= 1'b0;
        end else if (wr_acc && !is_arr && idx == `SCM_IDX_PROG) begin
            volt_q <= pwdata[`SCM_PROG_VOLT_BIT] && latch_q;
            if (!volt_q || !pwdata[`SCM_PROG_VOLT_BIT]) begin
                latch_q <= pwdata[`SCM_PROG_LATCH_BIT];
            end
        end
    end

    assign array_latch_enable = latch_q || u_latch;
    assign program_voltage_enable = volt_q || u_prog;

    // Stop exit delay, long only when the crystal needs settling
    always_ff @(posedge clk) begin
        if (rst) begin
            stop_q <= 13'h0;
        end else if (stop_exit) begin
            stop_q <= opt_q[`SCM_OPT_DLY_BIT] ? `SCM_STOP_SLOW_CYCLES
                : `SCM_STOP_FAST_CYCLES;
        end else if (stop_q != 13'h0) begin
            stop_q <= stop_q - 13'h1;
        end
    end
    assign resume_run = (stop_q == 13'h1);

    // Free-running prescaler; rate bits widen the terminal count
    always_ff @(posedge clk) begin
        if (rst) begin
            wd_q <= 21'h0;
        end else begin
            wd_q <= wd_q + 21'h1;
        end
    end
    assign wd_mask = 21'((64'h1 << (`SCM_WD_DIV_LOG2
        + 2 * int'(opt_q[1:0]))) - 64'h1);
    assign watchdog_tick = &(wd_q | ~wd_mask);

    // Resident utility engine, exits only through reset
    always_ff @(posedge clk) begin
        if (rst) begin
            ust_q <= U_IDLE;
            dly_q <= 16'h0;
            ptr_q <= 16'h0;
            ucnt_q <= 16'h0;
            hold_q <= 8'h0;
            tx_q <= 8'h0;
        end else begin
            case (ust_q)
                U_IDLE: begin
                    if (boot_jump && special_mode) begin
                        dly_q <= `SCM_UTIL_DLY_RESET;
                        ptr_q <= `SCM_UTIL_PTR_RESET;
                        tx_q <= `SCM_READY_CHAR;
                        ust_q <= U_HELLO;
                    end
                end
                U_HELLO: begin
                    if (tx_ready) begin
                        ust_q <= U_WAIT;
                    end
                end
                U_WAIT: begin
                    if (rx_valid) begin
                        hold_q <= rx_data;
                        ucnt_q <= (dly_q == 16'h0) ? 16'h1 : dly_q;
                        ust_q <= U_PROG;
                    end
                end
                U_PROG: begin
                    ucnt_q <= ucnt_q - 16'h1;
                    if (ucnt_q == 16'h1) begin
                        tx_q <= arr_rd & hold_q;
                        ust_q <= U_VERIFY;
                    end
                end
                U_VERIFY: begin
                    if (tx_ready) begin
                        ptr_q <= ptr_q + 16'h1;
                        ust_q <= U_WAIT;
                    end
                end
                default: ust_q <= U_IDLE;
            endcase
        end
    end

    assign util_busy = (ust_q != U_IDLE);
    assign u_latch = (ust_q == U_WAIT) && rx_valid;
    assign u_prog = (ust_q == U_PROG);
    assign tx_valid = (ust_q == U_HELLO) || (ust_q == U_VERIFY);
    assign tx_data = tx_q;
    assign arr_rd_addr = util_busy ? ptr_q[AW-1:0] : paddr[AW+1:2];

    scm_eprom_array #(.DEPTH(DEPTH), .AW(AW)) u_arr (
        .clk(clk),
        .uv_erase(uv_erase),
        .latch_en(util_busy ? u_latch : (wr_acc && is_arr)),
        .latch_addr(util_busy ? ptr_q[AW-1:0] : paddr[AW+1:2]),
        .latch_data(util_busy ? rx_data : pwdata[7:0]),
        .prog_en(util_busy ? u_prog : (volt_q && latch_q)),
        .rd_addr(arr_rd_addr),
        .rd_data(arr_rd)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_stop_fast;
        stop_exit && !opt_q[`SCM_OPT_DLY_BIT];
    endsequence
    sequence s_stop_slow;
        stop_exit && opt_q[`SCM_OPT_DLY_BIT];
    endsequence

    chk_stop_fast: assert property (s_stop_fast ##1 !stop_exit [*4]
        |-> resume_run) else $error("fast stop exit not after four");
    chk_stop_slow: assert property (s_stop_slow ##1 !stop_exit
        |-> !resume_run [*8]) else $error("slow stop exit too early");
    chk_opt_locked: assert property (!special_mode && !win_open
        |=> $stable(opt_q & `SCM_OPT_PROT_MASK) || special_mode)
        else $error("protected option bits changed late");
    chk_window_len: assert property (
        $rose(win_q == `SCM_WINDOW_CYCLES) |-> $past(win_q) == 7'h3F)
        else $error("window length wrong");
    chk_bit2_zero: assert property (opt_q[2] == 1'b0)
        else $error("option bit 2 set");
    chk_volt_latch: assert property ($rose(volt_q)
        |-> $past(latch_q) && latch_q) else $error("voltage without latch");
    chk_clear_drops: assert property (wr_acc && !is_arr
        && idx == `SCM_IDX_PROG && pwdata[7:0] == 8'h00
        |=> !volt_q && !latch_q) else $error("clear kept programming");
    chk_util_hello: assert property (ust_q == U_IDLE && boot_jump
        && special_mode |=> tx_valid && tx_data == `SCM_READY_CHAR
        && ptr_q == `SCM_UTIL_PTR_RESET) else $error("no ready char");
    chk_map_base: assert property (reg_block_base[11:0] == 12'h000
        && reg_block_base[15:12] == map_q[3:0])
        else $error("register block not page aligned");
endmodule : scm_sysconfig
`default_nettype wire

// file: scm_host_model.sv
// Serial programming host: waits for the ready character, then sends
// one byte per handshake and keeps every verify byte it receives.
// Assumes the engine offers one transmit byte at a time.
`include "scm_cfg.svh"
`default_nettype none
module scm_host_model #(
    parameter int STALL = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_valid,
    input wire scm_pkg::scm_byte_t tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output scm_pkg::scm_byte_t rx_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import scm_pkg::*;
    scm_byte_t to_send[$];
    scm_byte_t got[$];
    logic hello_q = 1'b0;
    int wait_q = 0;
    logic go;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    always @(posedge clk) begin
        go = hello_q || tx_data == `SCM_READY_CHAR;
        rx_valid <= 1'b0;
        // Idle line toggles so a stale byte is never mistaken for data
        rx_data <= ~rx_data;
        if (rst) begin
            tx_ready <= 1'b0;
            hello_q <= 1'b0;
            wait_q <= 0;
        end else if (tx_valid && tx_ready) begin
            tx_ready <= 1'b0;
            wait_q <= 0;
            if (hello_q) begin
                got.push_back(tx_data);
            end
            if (go && to_send.size() > 0) begin
                hello_q <= 1'b1;
                rx_valid <= 1'b1;
                rx_data <= to_send.pop_front();
            end
        end else if (tx_valid) begin
            // Slow host: ready only after a few stalled cycles
            wait_q <= wait_q + 1;
            tx_ready <= (wait_q >= STALL);
        end
    end
endmodule : scm_host_model
`default_nettype wire

// file: scm_sysconfig_tb.sv
// Self-checking bench for the configuration block over APB.
// Assumes the host model on the serial side and a 200 MHz clock.
`include "scm_cfg.svh"
`default_nettype none
module scm_sysconfig_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import scm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic special_mode = 1'b0;
    logic uv_erase = 1'b0;
    logic stop_exit = 1'b0;
    logic boot_jump = 1'b0;
    logic [31:0] prdata;
    logic [15:0] reg_block_base, ram_base, rd_q;
    logic pready, pslverr, resume_run, converter_power_up, util_busy;
    logic pump_clock_select, edge_only_request_select, err_q;
    logic clock_monitor_enable, watchdog_tick, array_latch_enable;
    logic program_voltage_enable, rx_valid, tx_valid, tx_ready;
    scm_byte_t rx_data, tx_data;
    int err_total = 0;
    int n_compared = 0;
    int n;
    always #2.5 clk = ~clk;
    scm_sysconfig uut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .special_mode, .uv_erase,
        .stop_exit, .resume_run, .reg_block_base, .ram_base,
        .converter_power_up, .pump_clock_select, .edge_only_request_select,
        .clock_monitor_enable, .watchdog_tick, .array_latch_enable,
        .program_voltage_enable, .boot_jump, .rx_valid, .rx_data,
        .tx_valid, .tx_data, .tx_ready, .util_busy);
    scm_host_model host (.clk, .rst, .tx_valid, .tx_data, .tx_ready,
        .rx_valid, .rx_data);
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk
    task automatic bound(input int lim);
        if (n >= lim) begin
            err_total++;
            $display("mismatch at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask : bound
    task automatic wait_for(ref logic s, input int lim);
        n = 0;
        // Sampled at the falling edge, where design outputs have settled
        do begin
            @(negedge clk);
            n++;
        end while (s !== 1'b1 && n < lim);
        bound(lim);
    endtask : wait_for
    // Request held until the edge where pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        wait_for(pready, 20);
        // Answer taken while it stands; released after the pready edge
        rd_q = prdata[15:0];
        err_q = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic stop_time;
        @(posedge clk);
        stop_exit <= 1'b1;
        @(posedge clk);
        stop_exit <= 1'b0;
        wait_for(resume_run, 5000);
    endtask : stop_time
    task automatic erase;
        @(posedge clk);
        uv_erase <= 1'b1;
        repeat (2) @(posedge clk);
        uv_erase <= 1'b0;
    endtask : erase
    task automatic prog(input logic [5:0] i, input logic [7:0] d);
        // ROM map enable lives outside this block, taken as set
        apb(1'b1, 12'h0EC, 8'h20);
        apb(1'b0, {4'h4, i, 2'b00}, 8'h00);
        chk(err_q, 1'b1, "read while latched");
        apb(1'b1, {4'h4, i, 2'b00}, d);
        apb(1'b1, 12'h0EC, 8'h21);
        @(negedge clk);
        chk(program_voltage_enable, 1'b1, "voltage on");
        repeat (20) @(posedge clk);
        apb(1'b1, 12'h0EC, 8'h00);
        @(negedge clk);
        chk({array_latch_enable, program_voltage_enable}, 0, "off");
    endtask : prog
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 12'h0E4, 8'h00);
        chk(rd_q, `SCM_OPT_RESET, "option reset");
        apb(1'b0, 12'h0F4, 8'h00);
        chk(rd_q, 8'h01, "map reset");
        chk(reg_block_base, 16'h1000, "reg base");
        chk(ram_base, 16'h0000, "ram base");
        apb(1'b1, 12'h0E4, 8'hEC);
        apb(1'b0, 12'h0E4, 8'h00);
        chk(rd_q, 8'hE8, "option first");
        apb(1'b1, 12'h0F4, 8'h23);
        @(negedge clk);
        chk(reg_block_base, 16'h3000, "reg moved");
        chk(ram_base, 16'h2000, "ram moved");
        chk({converter_power_up, pump_clock_select, edge_only_request_select,
             clock_monitor_enable}, 4'hF, "option outs");
        apb(1'b1, 12'h0E4, 8'h13);
        apb(1'b0, 12'h0E4, 8'h00);
        chk(rd_q, 8'h20, "option second");
        repeat (64) @(posedge clk);
        apb(1'b1, 12'h0F4, 8'h05);
        apb(1'b0, 12'h0F4, 8'h00);
        chk(rd_q, 8'h23, "map late");
        stop_time();
        chk(n >= 4 && n <= 5, 1'b1, "fast resume");
        wait_for(watchdog_tick, 40000);
        wait_for(watchdog_tick, 40000);
        chk(n, 16'h8000, "watchdog period");
        apb(1'b0, 12'h004, 8'h00);
        chk(err_q, 1'b1, "unmapped");
        apb(1'b0, 12'h800, 8'h00);
        chk(err_q, 1'b1, "outside window");
        $display("test normal mode done");
        erase();
        apb(1'b0, 12'h414, 8'h00);
        chk(rd_q, 8'hFF, "erased");
        apb(1'b1, 12'h414, 8'h00);
        chk(err_q, 1'b1, "write unlatched");
        prog(6'd5, 8'hA5);
        apb(1'b0, 12'h414, 8'h00);
        chk(rd_q, 8'hA5, "programmed");
        prog(6'd5, 8'h5A);
        apb(1'b0, 12'h414, 8'h00);
        chk(rd_q, 8'h00, "zeros only");
        $display("test eprom done");
        special_mode <= 1'b1;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (70) @(posedge clk);
        apb(1'b1, 12'h0E4, 8'h13);
        apb(1'b0, 12'h0E4, 8'h00);
        chk(rd_q, 8'h13, "special late");
        apb(1'b1, 12'h0E4, 8'h10);
        apb(1'b0, 12'h0E4, 8'h00);
        chk(rd_q, 8'h10, "special again");
        stop_time();
        chk(n >= 4000 && n <= 4001, 1'b1, "slow resume");
        erase();
        host.to_send.push_back(8'h3C);
        host.to_send.push_back(8'h0F);
        @(posedge clk);
        boot_jump <= 1'b1;
        @(posedge clk);
        boot_jump <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (host.got.size() < 2 && n < 500);
        bound(500);
        chk(host.got[0], 8'h3C, "verify 0");
        chk(host.got[1], 8'h0F, "verify 1");
        chk(util_busy, 1'b1, "utility busy");
        apb(1'b0, 12'h0C8, 8'h00);
        chk(rd_q, 16'h0002, "utility waits");
        apb(1'b0, 12'h0C4, 8'h00);
        chk(rd_q, 16'hD002, "pointer");
        apb(1'b0, 12'h0C0, 8'h00);
        chk(rd_q, `SCM_UTIL_DLY_RESET, "delay");
        // Utility owns the array address until reset ends the session
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(util_busy, 1'b0, "idle after reset");
        apb(1'b0, 12'h400, 8'h00);
        chk(rd_q, 8'h3C, "cell 0");
        apb(1'b0, 12'h404, 8'h00);
        chk(rd_q, 8'h0F, "cell 1");
        $display("test special mode done");
        report_and_stop();
    end
endmodule : scm_sysconfig_tb
`default_nettype wire
